//--- rtl/pscf_pkg.sv
/*
 * Shared constants of the potentiometer serial command link: frame layout,
 * instruction codes, widths and timing.
 * Assumes both ends and the bench run from a 125 MHz reference clock.
 */
`default_nettype none
package pscf_pkg;
    // Device-type code in the identifier byte; value is arbitrary
    localparam logic [3:0] DEV_TYPE      = 4'h6;

    localparam logic [3:0] OP_WIPER_RD   = 4'h8;
    localparam logic [3:0] OP_WIPER_WR   = 4'ha;  // Read direction: stored-position read
    localparam logic [3:0] OP_STORE_WR   = 4'hc;  // Read direction: recall store to wiper
    localparam logic [3:0] OP_SAVE       = 4'he;
    localparam logic [3:0] OP_STATUS     = 4'h4;
    localparam logic [3:0] STATUS_LOW    = 4'h1;
    localparam logic [1:0] PAD_LOW       = 2'h0;

    localparam int         ID_TYPE_LSB   = 4;
    localparam int         ID_ZERO_BIT   = 3;
    localparam int         ID_ADDR_LSB   = 1;
    localparam int         ID_RW_BIT     = 0;
    localparam int         INS_OP_LSB    = 4;
    localparam int         INS_SEL_LSB   = 2;
    localparam int         INS_LOW_LSB   = 0;

    localparam int         BYTE_BITS     = 8;
    localparam int         HDR_BITS      = 16;
    localparam int         FRAME_BITS    = 32;
    localparam int         DATA_W        = 16;
    localparam int         POS_W         = 10;
    localparam int         PAD_W         = 6;
    localparam int         SLOTS         = 4;
    localparam int         CNT_W         = 6;

    localparam logic [POS_W-1:0] POS_RESET = 10'h000;

    localparam int         CLK_PERIOD_NS = 8;
    localparam int         NV_WRITE_NS   = 10000;
    localparam int         NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SCK_HALF_CYC  = 12;
endpackage
`default_nettype wire

//--- rtl/pscf_if.sv
/*
 * Serial link between host controller and potentiometer device.
 * Assumes the host resolves the serial output wire from so and so_oe.
 */
`default_nettype none
interface pscf_if;
    logic cs_n;   // Chip select, active low
    logic sck;    // Serial clock from host
    logic si;     // Host to device data
    logic so;     // Device to host data
    logic so_oe;  // Device drives so while high

    modport device (input cs_n, input sck, input si, output so, output so_oe);
    modport host   (output cs_n, output sck, output si, input so, input so_oe);
endinterface
`default_nettype wire

//--- rtl/pscf_device.sv
/*
 * Device end: decodes serial command frames, holds the wiper position and
 * four stored positions, and models the nonvolatile write cycle timing.
 * Assumes the host runs serial mode 0 with sck half periods well above
 * the synchroniser delay, and address straps that are static.
 */
`default_nettype none
// Behaviour
// - Frame: falling select, identifier byte, address match
// - Wiper read returns pad then ten bits
// - Wiper write loads wiper at frame end
// - Stored read returns selected store's bits
// - Stored write starts nonvolatile cycle at end
// - Recall frame copies store into wiper
// - Save frame copies wiper, starts nonvolatile cycle
// - Status read: pad, nine zeros, busy
// - Data phase: ten low bits, padding ignored
// - Busy flag high only during nonvolatile write
// - Store commits only after complete frame
module pscf_device #(
    parameter int NV_WRITE_CYCLES = pscf_pkg::NV_WRITE_CYC
) (
    input  wire logic                       REF_CLK,    // Reference clock
    input  wire logic                       RESETN,     // Async reset, active low
    pscf_if.device                          LINK,       // Serial link
    input  wire logic [1:0]                 ADDR_STRAP, // Slave address pins
    output var  logic [pscf_pkg::POS_W-1:0] WIPER_POS,  // Current wiper position
    output var  logic                       WRITE_BUSY  // Nonvolatile write running
);
    localparam int NIN = 5;
    localparam int IX_CS = 0;
    localparam int IX_SCK = 1;
    localparam int IX_SI = 2;
    localparam int IX_ADR = 3;
    localparam logic [NIN-1:0] SYNC_RST = 5'h01;
    localparam int BW = $clog2(NV_WRITE_CYCLES + 1);
    localparam logic [BW-1:0] BUSY_LOAD = BW'(NV_WRITE_CYCLES);
    localparam logic [BW-1:0] BUSY_LAST = BW'(1);
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_MAX = '1;
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_ID = pscf_pkg::CNT_W'(pscf_pkg::BYTE_BITS - 1);
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_INS = pscf_pkg::CNT_W'(pscf_pkg::HDR_BITS - 1);
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_HDR = pscf_pkg::CNT_W'(pscf_pkg::HDR_BITS);
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_DAT = pscf_pkg::CNT_W'(pscf_pkg::FRAME_BITS - 1);
    localparam logic [pscf_pkg::CNT_W-1:0] CNT_FULL = pscf_pkg::CNT_W'(pscf_pkg::FRAME_BITS);

    // Refused at elaboration: the busy counter needs a load and a last cycle
    if (NV_WRITE_CYCLES < 2) begin : g_bad_nv
        $error("NV_WRITE_CYCLES must be at least 2");
    end

    typedef enum logic [6:0] {
        CMD_NONE     = 7'h01,
        CMD_WIPER_RD = 7'h02,
        CMD_WIPER_WR = 7'h04,
        CMD_STORE_RD = 7'h08,
        CMD_STORE_WR = 7'h10,
        CMD_RECALL   = 7'h20,
        CMD_SAVE     = 7'h40
    } pscf_cmd_e;

    // Status read is kept apart: it shares no opcode with the table above
    function automatic pscf_cmd_e decode(input logic rw, input logic [7:0] ins);
        logic [3:0] op;
        logic [1:0] low;
        logic [1:0] sel;
        op  = ins[pscf_pkg::INS_OP_LSB +: 4];
        low = ins[pscf_pkg::INS_LOW_LSB +: 2];
        sel = ins[pscf_pkg::INS_SEL_LSB +: 2];
        decode = CMD_NONE;
        if (low == pscf_pkg::PAD_LOW) begin
            case ({rw, op})
                {1'b1, pscf_pkg::OP_WIPER_RD}: decode = (sel == 2'h0) ? CMD_WIPER_RD : CMD_NONE;
                {1'b0, pscf_pkg::OP_WIPER_WR}: decode = (sel == 2'h0) ? CMD_WIPER_WR : CMD_NONE;
                {1'b1, pscf_pkg::OP_WIPER_WR}: decode = CMD_STORE_RD;
                {1'b0, pscf_pkg::OP_STORE_WR}: decode = CMD_STORE_WR;
                {1'b1, pscf_pkg::OP_STORE_WR}: decode = CMD_RECALL;
                {1'b0, pscf_pkg::OP_SAVE}:     decode = CMD_SAVE;
                default:                       decode = CMD_NONE;
            endcase
        end
    endfunction

    function automatic logic is_status(input logic rw, input logic [7:0] ins);
        is_status = rw && (ins == {pscf_pkg::OP_STATUS, pscf_pkg::STATUS_LOW});
    endfunction

    logic [NIN-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
    logic           cs_n_f, sck_f, si_f, frame_on;
    logic           sck_rise, sck_fall, cs_fall, cs_rise;
    logic [1:0]     addr_f;

    // Three-stage sampling; a level counts once stages two and three agree
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            s3_q <= SYNC_RST;
            f_q  <= SYNC_RST;
            fp_q <= SYNC_RST;
        end else begin
            s1_q <= {ADDR_STRAP, LINK.si, LINK.sck, LINK.cs_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
            fp_q <= f_q;
        end
    end

    assign cs_n_f   = f_q[IX_CS];
    assign sck_f    = f_q[IX_SCK];
    assign si_f     = f_q[IX_SI];
    assign addr_f   = f_q[IX_ADR +: 2];
    assign frame_on = !cs_n_f && !fp_q[IX_CS];
    assign cs_fall  = !cs_n_f && fp_q[IX_CS];
    assign cs_rise  = cs_n_f && !fp_q[IX_CS];
    assign sck_rise = frame_on && sck_f && !fp_q[IX_SCK];
    assign sck_fall = frame_on && !sck_f && fp_q[IX_SCK];

    logic [pscf_pkg::CNT_W-1:0]  cnt_q;
    logic [pscf_pkg::DATA_W-1:0] in_q, in_nxt, out_q;
    logic [7:0]                  ins_q;
    logic                        id_ok_q, rw_q, rd_on_q, so_q;
    logic [pscf_pkg::POS_W-1:0]  data_q, wiper_q;
    logic [pscf_pkg::POS_W-1:0]  slot_q [pscf_pkg::SLOTS];
    logic [BW-1:0]               busy_q;
    logic [1:0]                  nv_sel_q;
    logic [pscf_pkg::POS_W-1:0]  nv_val_q;
    pscf_cmd_e                   cmd;
    logic [1:0]                  sel;

    assign in_nxt = {in_q[pscf_pkg::DATA_W-2:0], si_f};
    assign cmd    = decode(rw_q, ins_q);
    assign sel    = ins_q[pscf_pkg::INS_SEL_LSB +: 2];

    // Bit counter, identifier check and instruction capture
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_q   <= '0;
            in_q    <= '0;
            ins_q   <= '0;
            id_ok_q <= 1'b0;
            rw_q    <= 1'b0;
            data_q  <= '0;
        end else if (cs_fall) begin
            cnt_q   <= '0;
            id_ok_q <= 1'b0;
        end else if (sck_rise) begin
            in_q  <= in_nxt;
            cnt_q <= (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 1'b1;
            if (cnt_q == CNT_ID) begin
                id_ok_q <= in_nxt[pscf_pkg::ID_TYPE_LSB +: 4] == pscf_pkg::DEV_TYPE
                        && !in_nxt[pscf_pkg::ID_ZERO_BIT]
                        && in_nxt[pscf_pkg::ID_ADDR_LSB +: 2] == addr_f;
                rw_q    <= in_nxt[pscf_pkg::ID_RW_BIT];
            end
            if (cnt_q == CNT_INS) begin
                ins_q <= in_nxt[7:0];
            end
            if (cnt_q == CNT_DAT) begin
                data_q <= in_nxt[pscf_pkg::POS_W-1:0];
            end
        end
    end

    // Read data launched on falling sck, first bit after the instruction byte
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            out_q   <= '0;
            rd_on_q <= 1'b0;
            so_q    <= 1'b0;
        end else if (cs_fall || cs_rise) begin
            rd_on_q <= 1'b0;
        end else if (sck_rise && cnt_q == CNT_INS) begin
            rd_on_q <= 1'b0;
            if (id_ok_q && is_status(rw_q, in_nxt[7:0])) begin
                out_q   <= {{(pscf_pkg::DATA_W-1){1'b0}}, WRITE_BUSY};
                rd_on_q <= 1'b1;
            end else if (id_ok_q) begin
                case (decode(rw_q, in_nxt[7:0]))
                    CMD_WIPER_RD: begin
                        out_q   <= {{pscf_pkg::PAD_W{1'b0}}, wiper_q};
                        rd_on_q <= 1'b1;
                    end
                    CMD_STORE_RD: begin
                        out_q   <= {{pscf_pkg::PAD_W{1'b0}}, slot_q[in_nxt[pscf_pkg::INS_SEL_LSB +: 2]]};
                        rd_on_q <= 1'b1;
                    end
                    default: rd_on_q <= 1'b0;
                endcase
            end
        end else if (sck_rise && cnt_q == CNT_DAT) begin
            rd_on_q <= 1'b0;
        end else if (sck_fall && rd_on_q) begin
            so_q  <= out_q[pscf_pkg::DATA_W-1];
            out_q <= {out_q[pscf_pkg::DATA_W-2:0], 1'b0};
        end
    end

    assign LINK.so    = so_q;
    assign LINK.so_oe = rd_on_q && !cs_n_f;

    logic end_ok, wr_wiper, recall, nv_start;
    logic [pscf_pkg::POS_W-1:0] nv_val;

    // Frame end acts only for a matched frame of exactly the right length
    assign end_ok   = cs_rise && id_ok_q;
    assign wr_wiper = end_ok && cmd == CMD_WIPER_WR && cnt_q == CNT_FULL;
    assign recall   = end_ok && cmd == CMD_RECALL && cnt_q == CNT_HDR;
    // A new store request during a running cycle is dropped, not queued
    assign nv_start = busy_q == '0 && end_ok
                   && ((cmd == CMD_STORE_WR && cnt_q == CNT_FULL)
                    || (cmd == CMD_SAVE && cnt_q == CNT_HDR));
    assign nv_val   = (cmd == CMD_SAVE) ? wiper_q : data_q;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wiper_q <= pscf_pkg::POS_RESET;
        end else if (wr_wiper) begin
            wiper_q <= data_q;
        end else if (recall) begin
            wiper_q <= slot_q[sel];
        end
    end

    // Nonvolatile cycle: store updated when the busy time expires
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_q   <= '0;
            nv_sel_q <= '0;
            nv_val_q <= '0;
            for (int i = 0; i < pscf_pkg::SLOTS; i++) begin
                slot_q[i] <= pscf_pkg::POS_RESET;
            end
        end else if (nv_start) begin
            busy_q   <= BUSY_LOAD;
            nv_sel_q <= sel;
            nv_val_q <= nv_val;
        end else if (busy_q != '0) begin
            busy_q <= busy_q - 1'b1;
            if (busy_q == BUSY_LAST) begin
                slot_q[nv_sel_q] <= nv_val_q;
            end
        end
    end

    assign WIPER_POS  = wiper_q;
    assign WRITE_BUSY = busy_q != '0;
endmodule
`default_nettype wire

//--- rtl/pscf_host.sv
/*
 * Host end: turns one user command into a serial frame, makes sck by
 * dividing the reference clock, and returns the read data word.
 * Assumes the device answers within one sck half period.
 */
`default_nettype none
module pscf_host #(
    parameter int HALF_CYC = pscf_pkg::SCK_HALF_CYC
) (
    input  wire logic                        REF_CLK,   // Reference clock
    input  wire logic                        RESETN,    // Async reset, active low
    pscf_if.host                             LINK,      // Serial link
    input  wire logic                        CMD_VALID, // Command request
    output logic                             CMD_READY, // Idle, takes command
    input  wire logic                        CMD_RW,    // Direction bit, 1 read
    input  wire logic [3:0]                  CMD_OP,    // Instruction nibble
    input  wire logic [1:0]                  CMD_SEL,   // Store select
    input  wire logic [1:0]                  CMD_ADDR,  // Slave address
    input  wire logic [pscf_pkg::POS_W-1:0]  CMD_DATA,  // Position to send
    output var  logic                        RSP_VALID, // Frame done pulse
    output var  logic [pscf_pkg::DATA_W-1:0] RSP_DATA   // Last sixteen bits read
);
    localparam int TW = $clog2(HALF_CYC + 1);
    localparam logic [TW-1:0] T_LOAD = TW'(HALF_CYC - 1);
    localparam logic [pscf_pkg::CNT_W-1:0] N_SHORT = pscf_pkg::CNT_W'(pscf_pkg::HDR_BITS);
    localparam logic [pscf_pkg::CNT_W-1:0] N_LONG = pscf_pkg::CNT_W'(pscf_pkg::FRAME_BITS);

    if (HALF_CYC < 10) begin : g_bad_half
        $error("HALF_CYC below synchroniser round trip");
    end

    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_LEAD = 6'h02,
        H_LOW  = 6'h04,
        H_HIGH = 6'h08,
        H_TAIL = 6'h10,
        H_GAP  = 6'h20
    } pscf_hst_e;

    pscf_hst_e                        st_q;
    logic [TW-1:0]                    t_q;
    logic [pscf_pkg::FRAME_BITS-1:0]  tx_q;
    logic [pscf_pkg::DATA_W-1:0]      rx_q;
    logic [pscf_pkg::CNT_W-1:0]       n_q, bits_q;
    logic [2:0]                       so_s_q;
    logic                             cs_n_q, sck_q, si_q, t_done, two_byte;
    logic                             so_f_q;
    logic [7:0]                       ins;

    assign t_done    = t_q == '0;
    assign CMD_READY = st_q == H_IDLE;
    assign two_byte  = (CMD_RW && CMD_OP == pscf_pkg::OP_STORE_WR) || (!CMD_RW && CMD_OP == pscf_pkg::OP_SAVE);
    assign ins       = (CMD_RW && CMD_OP == pscf_pkg::OP_STATUS) ? {CMD_OP, pscf_pkg::STATUS_LOW}
                                                                 : {CMD_OP, CMD_SEL, pscf_pkg::PAD_LOW};

    // Undriven output reads as zero; a level counts once stages two and three agree
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            so_s_q <= '0;
            so_f_q <= 1'b0;
        end else begin
            so_s_q <= {so_s_q[1:0], LINK.so && LINK.so_oe};
            if (so_s_q[1] == so_s_q[2]) begin
                so_f_q <= so_s_q[2];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q      <= H_IDLE;
            t_q       <= '0;
            tx_q      <= '0;
            rx_q      <= '0;
            n_q       <= '0;
            bits_q    <= '0;
            cs_n_q    <= 1'b1;
            sck_q     <= 1'b0;
            si_q      <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_DATA  <= '0;
        end else begin
            RSP_VALID <= 1'b0;
            t_q       <= t_done ? '0 : t_q - 1'b1;
            case (st_q)
                H_IDLE: begin
                    if (CMD_VALID) begin
                        // Identifier, instruction, then six pad bits and the position
                        tx_q   <= {pscf_pkg::DEV_TYPE, 1'b0, CMD_ADDR, CMD_RW, ins,
                                   {pscf_pkg::PAD_W{1'b0}}, CMD_DATA};
                        bits_q <= two_byte ? N_SHORT : N_LONG;
                        n_q    <= '0;
                        cs_n_q <= 1'b0;
                        t_q    <= T_LOAD;
                        st_q   <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (t_done) begin
                        si_q <= tx_q[pscf_pkg::FRAME_BITS-1];
                        t_q  <= T_LOAD;
                        st_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (t_done) begin
                        rx_q  <= {rx_q[pscf_pkg::DATA_W-2:0], so_f_q};
                        sck_q <= 1'b1;
                        t_q   <= T_LOAD;
                        st_q  <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (t_done) begin
                        sck_q <= 1'b0;
                        tx_q  <= {tx_q[pscf_pkg::FRAME_BITS-2:0], 1'b0};
                        si_q  <= tx_q[pscf_pkg::FRAME_BITS-2];
                        n_q   <= n_q + 1'b1;
                        t_q   <= T_LOAD;
                        st_q  <= (n_q + 1'b1 == bits_q) ? H_TAIL : H_LOW;
                    end
                end
                H_TAIL: begin
                    if (t_done) begin
                        cs_n_q <= 1'b1;
                        t_q    <= T_LOAD;
                        st_q   <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (t_done) begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= rx_q;
                        st_q      <= H_IDLE;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign LINK.cs_n = cs_n_q;
    assign LINK.sck  = sck_q;
    assign LINK.si   = si_q;
endmodule
`default_nettype wire

//--- test/pscf_link_asserts.sv
/* Link checker for the potentiometer serial link.
   Instantiated by the bench beside the link interface; one clock domain. */
`default_nettype none
module pscf_link_asserts #(
    parameter int NV = 20 // Nonvolatile write cycles
) (
    input wire logic       REF_CLK,   // Clock
    input wire logic       RESETN,    // Reset, active low
    input wire logic       cs_n,      // Chip select
    input wire logic       sck,       // Serial clock
    input wire logic       si,        // Host data
    input wire logic       so,        // Device data
    input wire logic       so_oe,     // Device drive enable
    input wire logic [9:0] WIPER_POS, // Wiper position
    input wire logic       WRITE_BUSY // Write running
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    logic       sck_q;
    logic [5:0] rises_q;
    logic       rw_q;
    int         busy_q;
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sck_q <= 1'h0;
        end else begin
            sck_q <= sck;
        end
    end
    // Raw edges: the device sees them a few cycles later
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rises_q <= 6'h00;
            rw_q <= 1'h0;
        end else if (cs_n) begin
            rises_q <= 6'h00;
        end else if (sck && !sck_q) begin
            rises_q <= rises_q + 6'h01;
            if (rises_q == 6'h07) begin
                rw_q <= si;
            end
        end
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_q <= 0;
        end else begin
            busy_q <= WRITE_BUSY ? busy_q + 1 : 0;
        end
    end
    oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("so_oe still high after frame end");
    oe_idle_a: assert property (cs_n [*8] |-> !so_oe)
        else $error("so_oe high while deselected");
    oe_start_a: assert property ($rose(so_oe) |-> !cs_n && rises_q == 6'h10)
        else $error("read data started at wrong bit");
    oe_read_a: assert property (so_oe |-> rw_q)
        else $error("so_oe high in a write frame");
    sck_idle_a: assert property (cs_n [*2] |-> !sck)
        else $error("sck high outside frame");
    cs_lead_a: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("sck rose too soon after select");
    so_hold_a: assert property (sck && sck_q && so_oe |-> $stable(so))
        else $error("so changed while sck high");
    wiper_frame_a: assert property (!cs_n [*8] |-> $stable(WIPER_POS))
        else $error("wiper changed inside a frame");
    busy_len_a: assert property ($fell(WRITE_BUSY) |-> busy_q == NV)
        else $error("busy length wrong");
    busy_max_a: assert property (busy_q <= NV)
        else $error("busy too long");
    busy_start_a: assert property ($rose(WRITE_BUSY) |-> cs_n && rises_q == 6'h00)
        else $error("write started inside a frame");
    cover property ($rose(WRITE_BUSY));
    cover property ($rose(so_oe));
    cover property ($fell(cs_n));
endmodule
`default_nettype wire

//--- test/tb_pot_serial_command_frames.sv
/* Bench: host end drives device end over the link, rows then odd cases.
   Assumes package, interface, both ends and the checker compiled first. */
`default_nettype none
module tb_pot_serial_command_frames;
    timeunit 1ns;
    timeprecision 1ps;
    // Long enough that a save overlaps two following frames
    localparam int NV = 2000;
    typedef struct packed {
        logic        rw;
        logic [3:0]  op;
        logic [1:0]  sel;
        logic [1:0]  addr;
        logic [9:0]  data;
        logic        chk;
        logic [15:0] rsp;
        logic [9:0]  pos;
    } pscf_row_s;
    logic        clk;
    logic        rst_n;
    logic        valid;
    logic        ready;
    logic        rsp_valid;
    logic [15:0] rsp;
    logic [9:0]  wpos;
    logic        busy;
    logic [1:0]  strap;
    pscf_row_s   cmd;
    int          n_errors;
    int          checks;
    pscf_row_s   rows [12] = '{
        '{1'h0, 4'ha, 2'h0, 2'h2, 10'h3a5, 1'h0, 16'h0000, 10'h3a5},
        '{1'h1, 4'h8, 2'h0, 2'h2, 10'h000, 1'h1, 16'h03a5, 10'h3a5},
        '{1'h0, 4'hc, 2'h2, 2'h2, 10'h155, 1'h0, 16'h0000, 10'h3a5},
        '{1'h1, 4'ha, 2'h2, 2'h2, 10'h000, 1'h1, 16'h0155, 10'h3a5},
        '{1'h1, 4'hc, 2'h2, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h155},
        '{1'h0, 4'ha, 2'h0, 2'h2, 10'h2aa, 1'h0, 16'h0000, 10'h2aa},
        '{1'h0, 4'he, 2'h1, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h2aa},
        '{1'h1, 4'ha, 2'h1, 2'h2, 10'h000, 1'h1, 16'h02aa, 10'h2aa},
        '{1'h1, 4'h4, 2'h0, 2'h2, 10'h000, 1'h1, 16'h0000, 10'h2aa},
        '{1'h0, 4'ha, 2'h0, 2'h1, 10'h0ff, 1'h0, 16'h0000, 10'h2aa},
        '{1'h0, 4'ha, 2'h1, 2'h2, 10'h0ff, 1'h0, 16'h0000, 10'h2aa},
        '{1'h1, 4'ha, 2'h3, 2'h2, 10'h000, 1'h1, 16'h0000, 10'h2aa}};
    pscf_if link ();
    pscf_host #(.HALF_CYC(12)) i_pscf_host (
        .REF_CLK   (clk),
        .RESETN    (rst_n),
        .LINK      (link.host),
        .CMD_VALID (valid),
        .CMD_READY (ready),
        .CMD_RW    (cmd.rw),
        .CMD_OP    (cmd.op),
        .CMD_SEL   (cmd.sel),
        .CMD_ADDR  (cmd.addr),
        .CMD_DATA  (cmd.data),
        .RSP_VALID (rsp_valid),
        .RSP_DATA  (rsp)
    );
    pscf_device #(.NV_WRITE_CYCLES(NV)) i_pscf_device (
        .REF_CLK    (clk),
        .RESETN     (rst_n),
        .LINK       (link.device),
        .ADDR_STRAP (strap),
        .WIPER_POS  (wpos),
        .WRITE_BUSY (busy)
    );
    pscf_link_asserts #(.NV(NV)) i_pscf_link_asserts (
        .REF_CLK    (clk),
        .RESETN     (rst_n),
        .cs_n       (link.cs_n),
        .sck        (link.sck),
        .si         (link.si),
        .so         (link.so),
        .so_oe      (link.so_oe),
        .WIPER_POS  (wpos),
        .WRITE_BUSY (busy)
    );
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp_rsp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t read word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pos(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t position %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic guard(input logic ok);
        if (ok !== 1'h1) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            complete_run();
        end
    endtask
    // Holds the request until the edge that takes it, then waits for the pulse
    task automatic send(input pscf_row_s r);
        int n;
        @(posedge clk);
        #1;
        cmd = r;
        valid = 1'h1;
        n = 0;
        // Ready is looked at between edges, where it has settled
        while (ready !== 1'h1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        guard(ready);
        @(posedge clk);
        #1;
        valid = 1'h0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rsp_valid !== 1'h1 && n < 2000);
        guard(rsp_valid);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 3 * NV) begin
            @(posedge clk);
            n++;
        end
        guard(!busy);
    endtask
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst_n = 1'h0;
        valid = 1'h0;
        cmd = '0;
        strap = 2'h2;
        n_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'h1;
        cmp_flag(busy, 1'h0);
        cmp_flag(link.so_oe, 1'h0);
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            wait_idle();
            send(rows[i]);
            if (rows[i].chk) begin
                cmp_rsp(rsp, rows[i].rsp);
            end
            cmp_pos(wpos, rows[i].pos);
        end
        // Status and a store write both land inside the save's write cycle
        send('{1'h0, 4'he, 2'h0, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h000});
        cmp_flag(busy, 1'h1);
        send('{1'h1, 4'h4, 2'h0, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h000});
        cmp_rsp(rsp, 16'h0001);
        send('{1'h0, 4'hc, 2'h0, 2'h2, 10'h011, 1'h0, 16'h0000, 10'h000});
        wait_idle();
        send('{1'h1, 4'ha, 2'h0, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h000});
        cmp_rsp(rsp, 16'h02aa);
        // Reset in the middle of a write cycle clears busy flag and wiper
        send('{1'h0, 4'he, 2'h3, 2'h2, 10'h000, 1'h0, 16'h0000, 10'h000});
        cmp_flag(busy, 1'h1);
        rst_n = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'h1;
        cmp_flag(busy, 1'h0);
        cmp_pos(wpos, 10'h000);
        complete_run();
    end
endmodule
`default_nettype wire
